// [include/lcd_pkg.sv]
// Package for the display controller two-wire slave port.
// Assumes a single core clock that oversamples the serial pins.
package lcd_pkg;
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h3a;
	localparam int MEM_DEPTH = 128;
	localparam int ADDR_W = 7;
	localparam logic [6:0] HOME_ADDR = 7'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] MEM_RESET = 8'h20;
	localparam logic [7:0] CMD_CLEAR = 8'h01;
	localparam logic [7:0] HOME_MASK = 8'hfe;
	localparam logic [7:0] HOME_CODE = 8'h02;
	localparam logic [7:0] SETADDR_MASK = 8'h80;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int CTRL_CONT_BIT = 7;
	localparam int CTRL_RS_BIT = 6;
endpackage : lcd_pkg

// [design/lcd_i2c_port.sv]
// Two-wire slave port of a character display controller.
// Assumes scl and sda inputs are already synchronous to core_clk.
// What this block does
// - Home instruction sets the address counter to zero and clears display shift.
// - Home instruction leaves the data register unchanged.
// - A read address copies the data register into the shifter in its acknowledge.
// - Register-select set with continuation clear makes later bytes memory data.
// - Read bytes go out over eight clocks, most significant bit first.
// - A master acknowledge prefetches the next location and advances the address.
// - A missing master acknowledge loads nothing into the shifter.
// - A missing master acknowledge leaves data, address and cursor unchanged.
// - Register-select decides whether later bytes are instructions or data.
// - An instruction starts on the clock of its acknowledge cycle.
`timescale 1ns/1ps
`default_nettype none
module lcd_i2c_port
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic address_select_pin,
	output logic sda_oe,
	output logic [6:0] addr_counter,
	output logic [6:0] display_shift
);
	// ****************************************
	// Bus events
	// ****************************************
	typedef enum logic [4:0]
	{
		LCD_IDLE = 5'h01,
		LCD_ADDR = 5'h02,
		LCD_CTRL = 5'h04,
		LCD_WDAT = 5'h08,
		LCD_RDAT = 5'h10
	} lcd_state_e;

	logic scl_d, sda_d;
	logic start_ev, stop_ev, rise, fall;
	assign start_ev = scl_in && scl_d && sda_d && !sda_in;
	assign stop_ev = scl_in && scl_d && !sda_d && sda_in;
	assign rise = scl_in && !scl_d;
	assign fall = !scl_in && scl_d;

	lcd_state_e st_r, st_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic ack_r, ack_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [7:0] dreg_r, dreg_nxt;
	logic [6:0] ac_r, ac_nxt;
	logic [6:0] shift_r, shift_nxt;
	logic rs_r, rs_nxt;
	logic cont_r, cont_nxt;
	logic oe_r, oe_nxt;
	logic [7:0] mem [0:lcd_pkg::MEM_DEPTH-1];
	logic mem_we;
	logic [7:0] byte_in;
	assign byte_in = {sh_r[6:0], sda_in};

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		ack_nxt = ack_r;
		sh_nxt = sh_r;
		tx_nxt = tx_r;
		dreg_nxt = dreg_r;
		ac_nxt = ac_r;
		shift_nxt = shift_r;
		rs_nxt = rs_r;
		cont_nxt = cont_r;
		oe_nxt = oe_r;
		mem_we = 1'b0;
		if (start_ev)
		begin
			st_nxt = LCD_ADDR;
			cnt_nxt = 3'h0;
			ack_nxt = 1'b0;
			oe_nxt = 1'b0;
		end
		else if (stop_ev)
		begin
			st_nxt = LCD_IDLE;
			oe_nxt = 1'b0;
		end
		else if (st_r != LCD_IDLE && rise && !ack_r)
		begin
			sh_nxt = byte_in;
			cnt_nxt = cnt_r + 3'h1;
			if (cnt_r == lcd_pkg::BIT_LAST)
				ack_nxt = 1'b1;
		end
		else if (st_r != LCD_IDLE && fall && !ack_r && st_r == LCD_RDAT)
		begin
			oe_nxt = !tx_r[3'h7 - cnt_r];
		end
		else if (ack_r && fall && !oe_r && st_r != LCD_RDAT)
		begin
			// Drive the acknowledge low for the ninth clock.
			if (st_r == LCD_ADDR && sh_r[7:1] !=
				{lcd_pkg::SLAVE_ADDR_BASE[6:1], address_select_pin})
			begin
				st_nxt = LCD_IDLE;
				ack_nxt = 1'b0;
			end
			else
				oe_nxt = 1'b1;
		end
		else if (ack_r && rise)
		begin
			ack_nxt = 1'b0;
			cnt_nxt = 3'h0;
			case (st_r)
				LCD_ADDR:
				begin
					if (sh_r[0])
					begin
						st_nxt = LCD_RDAT;
						tx_nxt = dreg_r;
					end
					else
						st_nxt = LCD_CTRL;
				end
				LCD_CTRL:
				begin
					cont_nxt = sh_r[lcd_pkg::CTRL_CONT_BIT];
					rs_nxt = sh_r[lcd_pkg::CTRL_RS_BIT];
					st_nxt = LCD_WDAT;
				end
				LCD_WDAT:
				begin
					// Execution begins on this acknowledge clock.
					if (rs_r)
					begin
						mem_we = 1'b1;
						ac_nxt = ac_r + 7'h01;
					end
					else if (sh_r == lcd_pkg::CMD_CLEAR)
					begin
						ac_nxt = lcd_pkg::HOME_ADDR;
						shift_nxt = 7'h00;
					end
					else if ((sh_r & lcd_pkg::HOME_MASK) == lcd_pkg::HOME_CODE)
					begin
						ac_nxt = lcd_pkg::HOME_ADDR;
						shift_nxt = 7'h00;
						// The data register is kept, so a read after home
						// returns stale content.
						dreg_nxt = dreg_r;
					end
					else if (sh_r[7])
					begin
						ac_nxt = sh_r[6:0];
						dreg_nxt = mem[sh_r[6:0]];
					end
					if (cont_r)
						st_nxt = LCD_CTRL;
				end
				LCD_RDAT:
				begin
					if (!sda_in)
					begin
						tx_nxt = mem[ac_r];
						dreg_nxt = mem[ac_r];
						ac_nxt = ac_r + 7'h01;
					end
					else
						st_nxt = LCD_IDLE;
				end
				default:
					st_nxt = LCD_IDLE;
			endcase
		end
		else if (ack_r && fall && st_r == LCD_RDAT)
			oe_nxt = 1'b0;
		else if (!ack_r && fall && oe_r && cnt_r == 3'h0)
			oe_nxt = 1'b0;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			st_r <= LCD_IDLE;
			cnt_r <= 3'h0;
			ack_r <= 1'b0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			dreg_r <= lcd_pkg::DATA_RESET;
			ac_r <= lcd_pkg::HOME_ADDR;
			shift_r <= 7'h00;
			rs_r <= 1'b0;
			cont_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else
		begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			ack_r <= ack_nxt;
			sh_r <= sh_nxt;
			tx_r <= tx_nxt;
			dreg_r <= dreg_nxt;
			ac_r <= ac_nxt;
			shift_r <= shift_nxt;
			rs_r <= rs_nxt;
			cont_r <= cont_nxt;
			oe_r <= oe_nxt;
		end
	end

	// Memory has no reset; it fills with blanks only by writes.
	always_ff @(posedge core_clk)
	begin
		if (mem_we)
			mem[ac_r] <= sh_r;
	end

	assign sda_oe = oe_r;
	assign addr_counter = ac_r;
	assign display_shift = shift_r;
endmodule : lcd_i2c_port
`default_nettype wire

// [tb/lcd_sva.sv]
// Port checks of lcd_i2c_port.
// Bound in below; sees ports only.
`timescale 1ns/1ps
`default_nettype none
module lcd_sva
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic [6:0] addr_counter,
	input wire logic [6:0] display_shift
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence hi2;
		scl_in ##1 scl_in;
	endsequence
	AST_HOME:
	assert property ($changed(addr_counter) && addr_counter == 7'h00
		|-> display_shift == 7'h00) else $error("shift");
	AST_OE_RISE:
	assert property ($rose(sda_oe) |-> !scl_in) else $error("rise");
	AST_OE_MIN:
	assert property ($rose(sda_oe) |-> sda_oe [*4]) else $error("short");
	AST_OE_FALL:
	assert property ($fell(sda_oe) |-> !scl_in) else $error("fall");
	AST_OE_HOLD:
	assert property (hi2 |-> $stable(sda_oe)) else $error("hold");
	AST_AC_TIME:
	assert property ($changed(addr_counter) |-> scl_in || $past(scl_in)
		|| $past(scl_in, 2)) else $error("late");
	AST_AC_LOW:
	assert property (!scl_in [*5] |-> $stable(addr_counter))
		else $error("drift");
	AST_AC_NACK:
	assert property ($changed(addr_counter) |-> !sda_in || !$past(sda_in)
		|| !$past(sda_in, 2)) else $error("nack");
endmodule : lcd_sva
bind lcd_i2c_port lcd_sva sva (.core_clk(core_clk), .resetn(resetn),
	.scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
	.addr_counter(addr_counter), .display_shift(display_shift));
`default_nettype wire

// [tb/lcd_mst.sv]
// Two-wire bus master model.
// Assumes the bench resolves sda_bus.
`timescale 1ns/1ps
`default_nettype none
module lcd_mst
(
	input wire logic core_clk,
	input wire logic sda_bus,
	output logic scl = 1'b1,
	output logic sda_m = 1'b1
);
	task ph;
		repeat (3) @(posedge core_clk);
	endtask : ph
	task bx(input logic b, output logic r);
		sda_m <= b;
		ph();
		scl <= 1'b1;
		ph();
		// Sample between edges, where the slave's drive has settled.
		@(negedge core_clk);
		r = sda_bus;
		ph();
		scl <= 1'b0;
		ph();
	endtask : bx
	task start;
		sda_m <= 1'b1;
		ph();
		scl <= 1'b1;
		ph();
		sda_m <= 1'b0;
		ph();
		scl <= 1'b0;
		ph();
	endtask : start
	task stop;
		sda_m <= 1'b0;
		ph();
		scl <= 1'b1;
		ph();
		sda_m <= 1'b1;
		ph();
	endtask : stop
	// Writes pass k high so the slave alone owns the line at the ack.
	task xf(input logic [7:0] o, input logic k, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--)
			bx(o[i], q[i]);
		bx(k, a);
	endtask : xf
endmodule : lcd_mst
`default_nettype wire

// [tb/lcd_ctrl_i2c_read_sequence_tb.sv]
// Bench for the two-wire display port.
// Uses lcd_mst; lcd_sva binds itself.
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_i2c_read_sequence_tb;
	logic [8:0] sq [9] = '{9'h174, 9'h040, 9'h048, 9'h049, 9'h174,
		9'h000, 9'h081, 9'h002, 9'h175};
	logic [15:0] rows [3] = '{16'h2481, 16'h2402, 16'ha482};
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic scl, sda_m, sda_oe, a;
	logic [6:0] ac, shift;
	logic sel = 1'b0;
	logic [7:0] q;
	int err_count = 0, tests_run = 0, cyc = 0;
	wire logic sda = sda_m & ~sda_oe;
	always #5 core_clk = ~core_clk;
	lcd_i2c_port dut (.core_clk(core_clk), .resetn(resetn), .scl_in(scl),
		.sda_in(sda), .address_select_pin(sel), .sda_oe(sda_oe),
		.addr_counter(ac), .display_shift(shift));
	lcd_mst m (.core_clk(core_clk), .sda_bus(sda), .scl(scl), .sda_m(sda_m));
	task chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_count++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask : chk
	task wrap_up;
		$display("%0d checks %0d wrong", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 9000)
		begin
			err_count++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (3) @(posedge core_clk);
		chk({sda_oe, ac}, 8'h00);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		foreach (sq[i])
		begin
			if (sq[i][8])
				m.start();
			m.xf(sq[i][7:0], 1'b1, q, a);
			chk({7'h00, a}, 8'h00);
		end
		chk({1'b0, ac}, {1'b0, lcd_pkg::HOME_ADDR});
		chk({1'b0, shift}, 8'h00);
		foreach (rows[i])
		begin
			m.xf(8'hff, rows[i][15], q, a);
			chk(q, rows[i][14:7]);
			chk({1'b0, ac}, {1'b0, rows[i][6:0]});
		end
		m.start();
		m.xf(8'h76, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
		// The select pin moves the address; then clear and continued control.
		sel <= 1'b1;
		m.start();
		m.xf(8'h76, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		m.xf(8'h80, 1'b1, q, a);
		m.xf(lcd_pkg::CMD_CLEAR, 1'b1, q, a);
		chk({1'b0, ac}, {1'b0, lcd_pkg::HOME_ADDR});
		m.xf(8'h80, 1'b1, q, a);
		m.xf(8'h85, 1'b1, q, a);
		m.xf(8'h40, 1'b1, q, a);
		m.xf(8'h5a, 1'b1, q, a);
		chk({1'b0, ac}, 8'h06);
		m.stop();
		// Reset in mid-run, then a read of the reset data register.
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({sda_oe, ac}, {1'b0, lcd_pkg::HOME_ADDR});
		chk({1'b0, shift}, 8'h00);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		m.start();
		m.xf(8'h77, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		m.xf(8'hff, 1'b1, q, a);
		chk(q, lcd_pkg::DATA_RESET);
		chk({1'b0, ac}, {1'b0, lcd_pkg::HOME_ADDR});
		wrap_up();
	end
endmodule : lcd_ctrl_i2c_read_sequence_tb
`default_nettype wire
